//--- design/guard_lock_regs.svh
`ifndef GUARD_LOCK_REGS_SVH
`define GUARD_LOCK_REGS_SVH
// ****************************************
// Timing figures in their own units.
// ****************************************
`define GL_CLK_MHZ          20
`define GL_TEST_PULSE_US    400
`define GL_TEST_PERIOD_US   20000
`define GL_ATTEMPT_US       200000
`define GL_BLINK_US         250000
`define GL_BLANK_US         1000
`define GL_DISCREPANCY_US   100000
`define GL_SETTLE_CYCLES    3
// ****************************************
// Cycle counts derived from the clock rate.
// ****************************************
`define GL_TEST_PULSE_CYC   (`GL_TEST_PULSE_US * `GL_CLK_MHZ)
`define GL_TEST_PERIOD_CYC  (`GL_TEST_PERIOD_US * `GL_CLK_MHZ)
`define GL_ATTEMPT_CYC      (`GL_ATTEMPT_US * `GL_CLK_MHZ)
`define GL_BLINK_CYC        (`GL_BLINK_US * `GL_CLK_MHZ)
`define GL_BLANK_CYC        (`GL_BLANK_US * `GL_CLK_MHZ)
`define GL_DISCREPANCY_CYC  (`GL_DISCREPANCY_US * `GL_CLK_MHZ)
`endif

//--- design/guard_lock_pkg.sv
package guard_lock_pkg;
	typedef enum logic [1:0] {
		CMD_NONE   = 2'h0,
		CMD_LOCK   = 2'h1,
		CMD_UNLOCK = 2'h2
	} cmd_t;

	typedef enum logic [3:0] {
		ST_INIT      = 4'h0,
		ST_UNLOCKED  = 4'h1,
		ST_LOCK1     = 4'h3,
		ST_LOCK2     = 4'h2,
		ST_LOCKED    = 4'h6,
		ST_UNLOCKING = 4'h7,
		ST_FAULT     = 4'h5,
		ST_PWRLOCK   = 4'h4,
		ST_EXIT      = 4'hC
	} state_t;
endpackage

//--- design/guard_lock_if.sv
`timescale 1ns/1ps
interface guard_lock_if;
	logic lockRequestInA;
	logic lockRequestInB;
	logic lockRequestRefIn;
	logic safeOutA;
	logic safeOutB;
	logic diagOut;

	modport dev (
		input  lockRequestInA,
		input  lockRequestInB,
		input  lockRequestRefIn,
		output safeOutA,
		output safeOutB,
		output diagOut
	);

	modport ctl (
		output lockRequestInA,
		output lockRequestInB,
		output lockRequestRefIn,
		input  safeOutA,
		input  safeOutB,
		input  diagOut
	);
endinterface

//--- design/guard_lock_device.sv
// Functional notes
// - Emergency exit switches both safety outputs off.
// - No self relock while emergency exit held.
// - Pos/pos: A,B high plus ref grounded unlocks.
// - Pos/neg: joined inputs, ref open locks.
// - Failed first lock drive retries once.
// - Second failed lock drive enters fault.
// - After fault, drive only on input change.
// - Locked at power-up needs unlock, relock.
// - Yellow LED flashes until that relock.
// - Outputs tested by off pulses, 0.4 ms.
// - Monitor tolerates off pulses up to 0.4 ms.
// - Monitor discrepancy time about 100 ms.
// - Monitor blanks pulses shorter than 1 ms.
// - Two independent p-type safety outputs.
// - Controller tests its own driving outputs; here it drives them as steady levels.
// - Active manual release flashes all LEDs.
`timescale 1ns/1ps
`include "guard_lock_regs.svh"
module guard_lock_device #(
	parameter logic [23:0] ATTEMPT_CYCLES = 24'(`GL_ATTEMPT_CYC),
	parameter logic [23:0] TEST_PERIOD    = 24'(`GL_TEST_PERIOD_CYC),
	parameter logic [23:0] TEST_PULSE     = 24'(`GL_TEST_PULSE_CYC),
	parameter logic [23:0] BLINK_CYCLES   = 24'(`GL_BLINK_CYC)
) (
	// Clock and reset.
	input  wire logic  clock,
	input  wire logic  sys_rst,
	// Link toward the controller and monitor.
	guard_lock_if.dev  link,
	// Wiring variant strap, high for positive/negative.
	input  wire logic  variantPn,
	// Bolt sensors and mechanical inputs.
	input  wire logic  boltLocked,
	input  wire logic  boltUnlocked,
	input  wire logic  emergencyExit,
	input  wire logic  manualRelease,
	// Bolt drive.
	output logic       boltExtend,
	output logic       boltRetract,
	// Status LEDs.
	output logic       ledYellow,
	output logic       ledRed,
	output logic       ledGreen
);
	import guard_lock_pkg::*;

	// ****************************************
	// Input synchronisers.
	// ****************************************
	logic [6:0] syncFirst;
	logic [6:0] syncSecond;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			syncFirst  <= 7'h00;
			syncSecond <= 7'h00;
		end else begin
			syncFirst  <= {link.lockRequestInA, link.lockRequestInB,
				link.lockRequestRefIn, boltLocked, boltUnlocked,
				emergencyExit, manualRelease};
			syncSecond <= syncFirst;
		end
	end

	wire inA       = syncSecond[6];
	wire inB       = syncSecond[5];
	wire refGnd    = syncSecond[4];
	wire isLocked  = syncSecond[3];
	wire isOpen    = syncSecond[2];
	wire exitHeld  = syncSecond[1];
	wire relActive = syncSecond[0];

	// ****************************************
	// Control input decoding.
	// ****************************************
	function automatic cmd_t decodeCmd(input logic a, input logic b,
		input logic r, input logic pn);
		if (a && b && r)
			return CMD_UNLOCK;
		else if (!a && !b && (pn ? !r : r))
			return CMD_LOCK;
		else
			return CMD_NONE;
	endfunction

	wire cmd_t cmd = decodeCmd(inA, inB, refGnd, variantPn);

	// ****************************************
	// Sequencer.
	// ****************************************
	state_t      state;
	state_t      next_state;
	cmd_t        faultCmd;
	cmd_t        lastCmd;
	logic [23:0] timer;
	logic [1:0]  settle;
	logic        relockPending;
	logic        releaseFlag;

	wire timeout   = (timer == ATTEMPT_CYCLES - 24'h000001);
	wire settled   = (settle == 2'(`GL_SETTLE_CYCLES - 1));
	wire cmdMoved  = (cmd != lastCmd);
	wire faultLeft = (cmd != faultCmd);

	always_comb begin
		next_state = state;
		if (exitHeld && state != ST_INIT) begin
			next_state = ST_EXIT;
		end else begin
			case (state)
				ST_INIT: begin
					if (settled)
						next_state = isLocked ? ST_PWRLOCK : ST_UNLOCKED;
				end
				ST_PWRLOCK: begin
					if (cmd == CMD_UNLOCK)
						next_state = ST_UNLOCKING;
				end
				ST_EXIT: begin
					next_state = ST_UNLOCKED;
				end
				ST_UNLOCKED: begin
					if (cmd == CMD_LOCK)
						next_state = ST_LOCK1;
				end
				ST_LOCK1: begin
					if (isLocked)
						next_state = ST_LOCKED;
					else if (cmd == CMD_UNLOCK)
						next_state = ST_UNLOCKING;
					else if (timeout)
						next_state = ST_LOCK2;
				end
				ST_LOCK2: begin
					if (isLocked)
						next_state = ST_LOCKED;
					else if (cmd == CMD_UNLOCK)
						next_state = ST_UNLOCKING;
					else if (timeout)
						next_state = ST_FAULT;
				end
				ST_LOCKED: begin
					if (cmd == CMD_UNLOCK)
						next_state = ST_UNLOCKING;
					else if (!isLocked)
						next_state = ST_LOCK1;
				end
				ST_UNLOCKING: begin
					if (isOpen)
						next_state = ST_UNLOCKED;
					else if (timeout)
						next_state = ST_FAULT;
				end
				ST_FAULT: begin
					if (faultLeft)
						next_state = (cmd == CMD_UNLOCK) ? ST_UNLOCKING
							: ST_UNLOCKED;
				end
				default: begin
					next_state = ST_INIT;
				end
			endcase
		end
	end

	wire enterFault  = (next_state == ST_FAULT) && (state != ST_FAULT);
	wire enterLocked = (next_state == ST_LOCKED) && (state != ST_LOCKED);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state         <= ST_INIT;
			timer         <= 24'h000000;
			settle        <= 2'h0;
			faultCmd      <= CMD_NONE;
			lastCmd       <= CMD_NONE;
			relockPending <= 1'b1;
			releaseFlag   <= 1'b0;
		end else begin
			state   <= next_state;
			lastCmd <= cmd;
			timer   <= (next_state != state) ? 24'h000000
				: timer + 24'h000001;
			if (!settled)
				settle <= settle + 2'h1;
			if (enterFault)
				faultCmd <= cmd;
			if (state == ST_INIT && settled && !isLocked)
				relockPending <= 1'b0;
			else if (enterLocked)
				relockPending <= 1'b0;
			if (relActive)
				releaseFlag <= 1'b1;
			else if (cmdMoved && cmd != CMD_NONE)
				releaseFlag <= 1'b0;
		end
	end

	// ****************************************
	// Safety outputs with staggered test pulses.
	// ****************************************
	logic [23:0] testCnt;
	always_ff @(posedge clock) begin
		if (sys_rst)
			testCnt <= 24'h000000;
		else if (testCnt == TEST_PERIOD - 24'h000001)
			testCnt <= 24'h000000;
		else
			testCnt <= testCnt + 24'h000001;
	end

	// Confirmed lock needs the state and the sensor to agree.
	wire safeAllowed = (state == ST_LOCKED) && isLocked
		&& !exitHeld;
	wire [23:0] halfPeriod = TEST_PERIOD >> 1;

	logic [1:0] safeReg;
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : gChannel
			wire [23:0] start = ch ? halfPeriod : 24'h000000;
			wire inPulse = (testCnt >= start)
				&& (testCnt < start + TEST_PULSE);
			always_ff @(posedge clock) begin
				if (sys_rst)
					safeReg[ch] <= 1'b0;
				else
					safeReg[ch] <= safeAllowed && !inPulse;
			end
		end
	endgenerate

	assign link.safeOutA = safeReg[1];
	assign link.safeOutB = safeReg[0];

	// ****************************************
	// Status LEDs and diagnostic output.
	// ****************************************
	logic [23:0] blinkCnt;
	logic        blink;
	logic        diagReg;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			blinkCnt <= 24'h000000;
			blink    <= 1'b0;
		end else if (blinkCnt == BLINK_CYCLES - 24'h000001) begin
			blinkCnt <= 24'h000000;
			blink    <= !blink;
		end else begin
			blinkCnt <= blinkCnt + 24'h000001;
		end
	end

	wire pwrBlink = relockPending && (state == ST_PWRLOCK
		|| state == ST_UNLOCKING || state == ST_UNLOCKED);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ledYellow   <= 1'b0;
			ledRed      <= 1'b0;
			ledGreen    <= 1'b0;
			diagReg     <= 1'b0;
			boltExtend  <= 1'b0;
			boltRetract <= 1'b0;
		end else begin
			boltExtend  <= (next_state == ST_LOCK1)
				|| (next_state == ST_LOCK2);
			boltRetract <= (next_state == ST_UNLOCKING);
			diagReg     <= safeAllowed;
			if (releaseFlag) begin
				ledYellow <= blink;
				ledRed    <= blink;
				ledGreen  <= blink;
			end else begin
				ledYellow <= pwrBlink ? blink
					: (state == ST_LOCKED);
				ledRed    <= (state == ST_FAULT);
				ledGreen  <= 1'b1;
			end
		end
	end

	assign link.diagOut = diagReg;
endmodule

//--- design/guard_lock_controller.sv
`timescale 1ns/1ps
`include "guard_lock_regs.svh"
module guard_lock_controller #(
	parameter logic [23:0] BLANK_CYCLES = 24'(`GL_BLANK_CYC),
	parameter logic [23:0] DISC_CYCLES  = 24'(`GL_DISCREPANCY_CYC)
) (
	// Clock and reset.
	input  wire logic  clock,
	input  wire logic  sys_rst,
	// Link toward the interlock.
	guard_lock_if.ctl  link,
	// User request and wiring variant.
	input  wire logic  lockWanted,
	input  wire logic  variantPn,
	// Evaluated status.
	output logic       guardLocked,
	output logic       discrepancyFault,
	output logic       diagSeen
);
	import guard_lock_pkg::*;

	// ****************************************
	// Control input drive.
	// ****************************************
	logic drvA;
	logic drvB;
	logic drvRef;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			drvA   <= 1'b0;
			drvB   <= 1'b0;
			drvRef <= 1'b1;
		end else begin
			drvA   <= !lockWanted;
			drvB   <= !lockWanted;
			drvRef <= !(lockWanted && variantPn);
		end
	end

	assign link.lockRequestInA   = drvA;
	assign link.lockRequestInB   = drvB;
	assign link.lockRequestRefIn = drvRef;

	// ****************************************
	// Dual-channel evaluation with blanking.
	// ****************************************
	logic [2:0] syncFirst;
	logic [2:0] syncSecond;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			syncFirst  <= 3'h0;
			syncSecond <= 3'h0;
		end else begin
			syncFirst  <= {link.safeOutA, link.safeOutB, link.diagOut};
			syncSecond <= syncFirst;
		end
	end

	logic [23:0] offCnt [2];
	logic [1:0]  chanOn;
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : gEval
			wire raw = syncSecond[ch + 1];
			always_ff @(posedge clock) begin
				if (sys_rst) begin
					offCnt[ch] <= 24'h000000;
					chanOn[ch] <= 1'b0;
				end else if (raw) begin
					offCnt[ch] <= 24'h000000;
					chanOn[ch] <= 1'b1;
				end else if (offCnt[ch] < BLANK_CYCLES) begin
					offCnt[ch] <= offCnt[ch] + 24'h000001;
				end else begin
					chanOn[ch] <= 1'b0;
				end
			end
		end
	endgenerate

	logic [23:0] discCnt;
	wire differ = chanOn[1] ^ chanOn[0];
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			discCnt          <= 24'h000000;
			discrepancyFault <= 1'b0;
			guardLocked      <= 1'b0;
			diagSeen         <= 1'b0;
		end else begin
			discCnt  <= differ ? discCnt + 24'h000001 : 24'h000000;
			diagSeen <= syncSecond[0];
			if (differ && discCnt >= DISC_CYCLES)
				discrepancyFault <= 1'b1;
			else if (chanOn == 2'h0)
				discrepancyFault <= 1'b0;
			guardLocked <= (chanOn == 2'h3) && !discrepancyFault;
		end
	end
endmodule

//--- testbench/guard_lock_monitor.sv
`timescale 1ns/1ps
module guard_lock_monitor #(
	parameter logic [23:0] TEST_PERIOD = 24'h000028,
	parameter logic [23:0] TEST_PULSE  = 24'h000004
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic sys_rst,
	// Link signals.
	input wire logic lockRequestInA,
	input wire logic lockRequestInB,
	input wire logic lockRequestRefIn,
	input wire logic safeOutA,
	input wire logic safeOutB,
	input wire logic diagOut
);
	logic [23:0] lowA;
	logic [23:0] lowB;
	logic [23:0] highA;

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	// Off run lengths of each channel and on run length of channel A while the guard reports locked.
	always_ff @(posedge clock) begin
		if (sys_rst || !diagOut) begin
			lowA <= 24'h000000;
			lowB <= 24'h000000;
			highA <= 24'h000000;
		end else begin
			lowA <= safeOutA ? 24'h000000 : lowA + 24'h000001;
			lowB <= safeOutB ? 24'h000000 : lowB + 24'h000001;
			highA <= safeOutA ? highA + 24'h000001 : 24'h000000;
		end
	end

	pulse_a_width_a: assert property (lowA <= TEST_PULSE)
		else $error("channel A off pulse too long");
	pulse_b_width_a: assert property (lowB <= TEST_PULSE)
		else $error("channel B off pulse too long");
	test_period_a: assert property (highA <= TEST_PERIOD)
		else $error("channel A not tested within a period");
	never_both_a: assert property (
		diagOut && $past(diagOut) |-> safeOutA || safeOutB)
		else $error("both channels off together while locked");
	out_diag_a: assert property (
		safeOutA || safeOutB |-> diagOut)
		else $error("safety output on while not confirmed locked");
	inputs_equal_a: assert property (
		lockRequestInA == lockRequestInB)
		else $error("control inputs one and two differ");
	unlock_ground_a: assert property (
		lockRequestInA |-> lockRequestRefIn)
		else $error("unlock request without grounded reference");
	reset_drive_a: assert property (
		$fell(sys_rst) |-> !lockRequestInA && lockRequestRefIn)
		else $error("controller does not request lock after reset");
	unlock_drop_a: assert property (
		$rose(lockRequestInA) |-> ##[1:5] !safeOutA && !safeOutB)
		else $error("outputs stay on after unlock request");
	lock_cause_a: assert property (
		$rose(diagOut) |-> !lockRequestInA && !$past(lockRequestInA, 3))
		else $error("locked without a held lock request");

	locked_c: cover property ($rose(diagOut));
	pulse_c: cover property (diagOut && $fell(safeOutA));
	unlock_c: cover property ($rose(lockRequestInA));
endmodule

//--- testbench/tb_guard_lock_bolt_controller.sv
`timescale 1ns/1ps
module tb_guard_lock_bolt_controller;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic variantPn = 1'b0;
	logic lockWanted = 1'b0;
	logic boltLocked = 1'b0;
	logic boltUnlocked = 1'b1;
	logic emergencyExit = 1'b0;
	logic manualRelease = 1'b0;
	logic boltExtend, boltRetract, ledYellow, ledRed, ledGreen;
	logic guardLocked, discrepancyFault, diagSeen;
	int err_total = 0;
	int comparisons = 0;
	int ny;
	int ng;

	guard_lock_if link ();
	always #25 clock = ~clock;

	guard_lock_device #(.ATTEMPT_CYCLES(24'h000032),
		.TEST_PERIOD(24'h000028), .TEST_PULSE(24'h000004),
		.BLINK_CYCLES(24'h000008)) guard_lock_device_i (
		.clock, .sys_rst, .link, .variantPn, .boltLocked, .boltUnlocked,
		.emergencyExit, .manualRelease, .boltExtend, .boltRetract,
		.ledYellow, .ledRed, .ledGreen);
	guard_lock_controller #(.BLANK_CYCLES(24'h00000A))
		guard_lock_controller_i (
		.clock, .sys_rst, .link, .lockWanted, .variantPn, .guardLocked,
		.discrepancyFault, .diagSeen);
	guard_lock_monitor guard_lock_monitor_i (
		.clock, .sys_rst, .lockRequestInA(link.lockRequestInA),
		.lockRequestInB(link.lockRequestInB),
		.lockRequestRefIn(link.lockRequestRefIn),
		.safeOutA(link.safeOutA), .safeOutB(link.safeOutB),
		.diagOut(link.diagOut));

	task automatic check(string name, logic seen, logic exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %b seen %b", name, exp, seen);
		end
	endtask

	task automatic cyc(int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic set_lock(logic v);
		@(posedge clock);
		lockWanted <= v;
	endtask

	task automatic sensors(logic locked);
		@(posedge clock);
		boltLocked <= locked;
		boltUnlocked <= ~locked;
	endtask

	task automatic do_reset();
		@(posedge clock);
		sys_rst <= 1'b1;
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		cyc(10);
	endtask

	// Counts toggles of the yellow and green LEDs over 40 cycles.
	task automatic blinks(output int y, output int g);
		logic py;
		logic pg;
		y = 0;
		g = 0;
		py = ledYellow;
		pg = ledGreen;
		repeat (40) begin
			cyc(1);
			if (ledYellow !== py) y++;
			if (ledGreen !== pg) g++;
			py = ledYellow;
			pg = ledGreen;
		end
	endtask

	task automatic do_lock();
		set_lock(1'b1);
		cyc(8);
		check("lock ref", link.lockRequestRefIn, ~variantPn);
		check("lock req a", link.lockRequestInA, 1'b0);
		check("extend", boltExtend, 1'b1);
		sensors(1'b1);
		cyc(40);
		check("extend off", boltExtend, 1'b0);
		check("diag", link.diagOut, 1'b1);
		check("diag seen", diagSeen, 1'b1);
		check("locked", guardLocked, 1'b1);
	endtask

	task automatic do_unlock();
		set_lock(1'b0);
		cyc(8);
		check("unlock ref", link.lockRequestRefIn, 1'b1);
		check("unlock req a", link.lockRequestInA, 1'b1);
		check("retract", boltRetract, 1'b1);
		sensors(1'b0);
		cyc(30);
		check("out a off", link.safeOutA, 1'b0);
		check("diag seen off", diagSeen, 1'b0);
		check("unlocked", guardLocked, 1'b0);
	endtask

	task automatic test_lock_cycle();
		do_lock();
		repeat (5) begin
			cyc(37);
			check("held", guardLocked, 1'b1);
			check("disc", discrepancyFault, 1'b0);
		end
		do_unlock();
	endtask

	task automatic test_retry_fault();
		set_lock(1'b1);
		cyc(80);
		check("retry", boltExtend, 1'b1);
		cyc(50);
		check("fault stop", boltExtend, 1'b0);
		check("fault led", ledRed, 1'b1);
		cyc(30);
		check("no redrive", boltExtend, 1'b0);
		set_lock(1'b0);
		cyc(15);
		set_lock(1'b1);
		cyc(8);
		check("redrive", boltExtend, 1'b1);
		sensors(1'b1);
		cyc(20);
		do_unlock();
	endtask

	task automatic test_emergency();
		do_lock();
		@(posedge clock);
		emergencyExit <= 1'b1;
		sensors(1'b0);
		cyc(5);
		check("exit a", link.safeOutA, 1'b0);
		check("exit b", link.safeOutB, 1'b0);
		cyc(80);
		check("no relock", boltExtend, 1'b0);
		check("exit diag", link.diagOut, 1'b0);
		set_lock(1'b0);
		cyc(10);
		@(posedge clock);
		emergencyExit <= 1'b0;
		cyc(10);
		check("exit left", boltExtend, 1'b0);
	endtask

	task automatic test_release();
		@(posedge clock);
		manualRelease <= 1'b1;
		cyc(5);
		@(posedge clock);
		manualRelease <= 1'b0;
		blinks(ny, ng);
		check("release blink", ng != 0, 1'b1);
		do_lock();
		blinks(ny, ng);
		check("release clear", ng == 0, 1'b1);
		do_unlock();
	endtask

	task automatic test_powerup_locked();
		sensors(1'b1);
		set_lock(1'b1);
		do_reset();
		blinks(ny, ng);
		check("pwr blink", ny != 0, 1'b1);
		check("pwr hold", boltExtend, 1'b0);
		check("pwr out", link.safeOutA, 1'b0);
		do_unlock();
		do_lock();
		blinks(ny, ng);
		check("pwr steady", ny == 0, 1'b1);
		do_unlock();
	endtask

	task automatic final_report();
		if (err_total == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		#(6000 * 50);
		err_total++;
		final_report();
	end

	initial begin
		do_reset();
		test_lock_cycle();
		test_retry_fault();
		test_emergency();
		test_release();
		test_powerup_locked();
		@(posedge clock);
		variantPn <= 1'b1;
		do_reset();
		do_lock();
		do_unlock();
		final_report();
	end
endmodule
